/* File: design/rtcc_pkg.sv */
/*
 * Shared constants and carrier types for the calendar page register block.
 * Assumes a single core clock domain and an AHB-Lite master doing
 * single whole-word transfers.
 */
package rtcc_pkg;

    // Low-speed timebase
    localparam int unsigned LS_CLK_HZ        = 32768;
    localparam int unsigned LS_EDGES_PER_SEC = LS_CLK_HZ;

    // Register byte offsets
    localparam logic [4:0] OFS_SEC   = 5'h00;
    localparam logic [4:0] OFS_MIN   = 5'h04;
    localparam logic [4:0] OFS_HOUR  = 5'h08;
    localparam logic [4:0] OFS_WDAY  = 5'h0c;
    localparam logic [4:0] OFS_DATE  = 5'h10;
    localparam logic [4:0] OFS_MONTH = 5'h14;
    localparam logic [4:0] OFS_YEAR  = 5'h18;
    localparam logic [4:0] OFS_CTL   = 5'h1c;

    // Control register and format bit positions
    localparam int unsigned CTL_PAGE_BIT  = 0;
    localparam int unsigned CTL_ALARM_BIT = 2;
    localparam int unsigned CTL_RUN_BIT   = 3;
    localparam int unsigned CTL_ROUND_BIT = 4;
    localparam int unsigned CTL_IRQ_BIT   = 7;
    localparam int unsigned FMT_BIT       = 0;

    // Writable field masks
    localparam logic [7:0] SEC_MASK   = 8'h7f;
    localparam logic [7:0] HOUR_MASK  = 8'h3f;
    localparam logic [7:0] WDAY_MASK  = 8'h07;
    localparam logic [7:0] DATE_MASK  = 8'h3f;
    localparam logic [7:0] MONTH_MASK = 8'h1f;
    localparam logic [7:0] LEAP_MASK  = 8'h03;

    // Reset values
    localparam logic [7:0] RST_SEC   = 8'h00;
    localparam logic [7:0] RST_HOUR  = 8'h00;
    localparam logic [7:0] RST_WDAY  = 8'h00;
    localparam logic [7:0] RST_DATE  = 8'h01;
    localparam logic [7:0] RST_MONTH = 8'h01;
    localparam logic [7:0] RST_YEAR  = 8'h00;
    localparam logic [1:0] RST_LEAP  = 2'h0;

    // BCD limits
    localparam logic [7:0] SEC_HALF    = 8'h30;
    localparam logic [7:0] BCD_59      = 8'h59;
    localparam logic [4:0] HOUR12_LAST = 5'h11;
    localparam logic [7:0] HOUR24_LAST = 8'h23;
    localparam logic [2:0] WDAY_LAST   = 3'h6;
    localparam logic [7:0] MONTH_LAST  = 8'h12;
    localparam logic [7:0] YEAR_LAST   = 8'h99;
    localparam logic [7:0] FEB         = 8'h02;

    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

    // Bus request from the master
    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
        logic        hready;
    } rtcc_ahb_req_t;

    // Bus response to the master
    typedef struct packed {
        logic        hreadyout;
        logic        hresp;
        logic [31:0] hrdata;
    } rtcc_ahb_rsp_t;

endpackage : rtcc_pkg

/* File: design/rtcc_regs.sv */
/*
 * Calendar page registers: clock page and alarm page behind one control
 * register, BCD timekeeping from a low-speed tick, AHB-Lite slave.
 * Assumes ls_clk_in is already synchronous to core_clk.
 */
// Contract
// RULE_01: Format 0: hour bit5 PM, 0-11 BCD
// RULE_02: Weekday 0 Sunday to 6 Saturday
// RULE_03: Date is BCD 1-31, bits 7:6 zero
// RULE_04: Software writes only real, valid dates
// RULE_05: Clock page month BCD 01-12
// RULE_06: Alarm page month address shows format bit
// RULE_07: Format not changed while clock runs
// RULE_08: Year BCD 00-99, fully writable
// RULE_09: Alarm page year address shows leap cycle
// RULE_10: Control bit0 selects clock or alarm page
// RULE_11: Control written whole, never read-modify-write
// RULE_12: Control bit3 runs or halts timekeeping
// RULE_13: Bit2 alarm enable, bit7 interrupt enable
// RULE_14: Interrupt enable set in a later write
// RULE_15: Rounding request latched, served at tick
// RULE_16: Seconds 0-29 clear without minute carry
// RULE_17: Seconds 30-59 clear and carry minute (the code drops the minute carry while the clock is halted)
// RULE_18: Rounding bit reads pending state
// RULE_19: Reset clears interrupt, request, page bits
// RULE_20: Prescaler makes one-second tick from 32.768kHz
// RULE_21: Format 1 gives 24-hour BCD hours
// RULE_22: True month lengths, leap cycle advances
// RULE_23: Reserved bits ignore writes, read zero
`timescale 1ns/1ps
`default_nettype none

module rtcc_regs #(
    parameter int unsigned LS_EDGES = rtcc_pkg::LS_EDGES_PER_SEC  // Low-speed edges per second
) (
    input  wire logic                    core_clk,        // Core clock, 20 MHz
    input  wire logic                    rst,             // Synchronous reset, high
    input  wire rtcc_pkg::rtcc_ahb_req_t ahb_req,         // Bus request
    output var  rtcc_pkg::rtcc_ahb_rsp_t ahb_rsp,         // Bus response
    input  wire logic                    ls_clk_in,       // 32.768 kHz level
    output var  logic                    clock_interrupt  // Alarm interrupt pulse
);
    import rtcc_pkg::*;

    // BCD increment by one
    function automatic logic [7:0] bcd_inc(input logic [7:0] v);
        if (v[3:0] == 4'h9) begin
            bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {v[7:4], v[3:0] + 4'h1};
        end
    endfunction : bcd_inc

    // Last day of the month in BCD
    function automatic logic [7:0] last_day(input logic [7:0] mon,
                                            input logic [1:0] leap);
        case (mon)
            FEB:     last_day = (leap == 2'h0) ? 8'h29 : 8'h28;
            8'h04,
            8'h06,
            8'h09,
            8'h11:   last_day = 8'h30;
            default: last_day = 8'h31;
        endcase
    endfunction : last_day

    // Address decode: hit and word index
    function automatic logic [3:0] decode(input logic [31:0] a);
        decode = {(a[31:5] == 27'h0) && (a[1:0] == 2'h0), a[4:2]};
    endfunction : decode

    // Calendar state
    logic [7:0]  sec_r;    // Seconds, BCD
    logic [7:0]  min_r;    // Minutes, BCD
    logic [7:0]  hour_r;   // Hour in the selected view
    logic [7:0]  date_r;   // Day of month, BCD
    logic [7:0]  month_r;  // Month, BCD
    logic [7:0]  year_r;   // Year, BCD
    logic [2:0] wday_r;
    logic [1:0] leap_r;
    logic       fmt_r;
    // Alarm page state
    logic [7:0] a_hour_r, a_date_r;
    logic [2:0] a_wday_r;
    // Control state
    logic        page_r;        // Alarm page selected
    logic        alarm_en_r;    // Alarm match enable
    logic        run_en_r;      // Timekeeping runs
    logic        irq_en_r;      // Interrupt output enable
    logic        round_pend_r;  // Seconds rounding pending
    // Bus state
    logic       wr_pend_r;
    logic [2:0] wr_idx_r;
    logic [31:0] rdata_r;
    // Prescaler
    logic        ls_prev_r;
    logic [15:0] pre_cnt_r;
    logic        tick_d_r;

    logic        ls_rise, sec_tick;
    logic        acc, rd_acc;
    logic [3:0]  dec;
    logic [7:0]  rd_val, wd;
    logic [7:0]  sec_nxt, min_nxt, hour_nxt, date_nxt, month_nxt, year_nxt;
    logic [2:0]  wday_nxt;
    logic [1:0]  leap_nxt;
    logic        min_c;   // Carry into minutes
    logic        hour_c;  // Carry into hours
    logic        day_c;   // Carry into the day
    logic        mon_c;   // Carry into the month
    logic        year_c;  // Carry into the year
    logic        alarm_match;
    logic [7:0]  h12_low;

    localparam logic [15:0] PRE_TERM = 16'(LS_EDGES - 1);

    // Prescaler on low-speed rising edges
    assign ls_rise  = ls_clk_in & ~ls_prev_r;
    assign sec_tick = ls_rise && (pre_cnt_r == PRE_TERM); // RULE_20

    always_ff @(posedge core_clk) begin
        if (rst) begin
            ls_prev_r <= 1'b0;
            pre_cnt_r <= 16'h0;
            tick_d_r  <= 1'b0;
        end else begin
            ls_prev_r <= ls_clk_in;
            tick_d_r  <= sec_tick;
            if (sec_tick) begin
                pre_cnt_r <= 16'h0; // RULE_20
            end else if (ls_rise) begin
                pre_cnt_r <= pre_cnt_r + 16'h1;
            end
        end
    end

    // Bus address phase and write data phase
    // A write lands one edge after its address, so a read issued back to
    // back to the same register still returns the old value
    assign dec    = decode(ahb_req.haddr);
    assign acc    = ahb_req.hsel && ahb_req.hready && (ahb_req.htrans == HTRANS_NONSEQ);
    assign rd_acc = acc && !ahb_req.hwrite;
    assign wd     = ahb_req.hwdata[7:0];

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_pend_r <= 1'b0;
            wr_idx_r  <= 3'h0;
        end else begin
            wr_pend_r <= acc && ahb_req.hwrite && dec[3];
            wr_idx_r  <= dec[2:0];
        end
    end

    // Data-phase write strobe for one register offset
    function automatic logic wr_at(input logic [4:0] ofs);
        wr_at = wr_pend_r && (wr_idx_r == ofs[4:2]);
    endfunction : wr_at

    // Carry chain for one tick
    always_comb begin
        sec_nxt   = sec_r;
        min_nxt   = min_r;
        hour_nxt  = hour_r;
        wday_nxt  = wday_r;
        date_nxt  = date_r;
        month_nxt = month_r;
        year_nxt  = year_r;
        leap_nxt  = leap_r;
        min_c     = 1'b0;
        hour_c    = 1'b0;
        day_c     = 1'b0;
        mon_c     = 1'b0;
        year_c    = 1'b0;
        h12_low   = bcd_inc({3'h0, hour_r[4:0]});
        // Seconds and rounding service
        if (sec_tick && round_pend_r) begin
            sec_nxt = 8'h00; // RULE_15
            if (sec_r >= SEC_HALF) begin
                // A halted clock drops the minute carry
                min_c = run_en_r; // RULE_17
            end else begin
                min_c = 1'b0; // RULE_16
            end
        end else if (sec_tick && run_en_r) begin // RULE_12
            if (sec_r == BCD_59) begin
                sec_nxt = 8'h00;
                min_c   = 1'b1;
            end else begin
                sec_nxt = bcd_inc(sec_r);
            end
        end
        // Minutes
        if (min_c) begin
            if (min_r == BCD_59) begin
                min_nxt = 8'h00;
                hour_c  = 1'b1;
            end else begin
                min_nxt = bcd_inc(min_r);
            end
        end
        // Hours in either view
        if (hour_c) begin
            if (fmt_r) begin
                if (hour_r == HOUR24_LAST) begin // RULE_21
                    hour_nxt = 8'h00;
                    day_c    = 1'b1;
                end else begin
                    hour_nxt = bcd_inc(hour_r);
                end
            end else if (hour_r[4:0] == HOUR12_LAST) begin // RULE_01
                hour_nxt = {2'b00, ~hour_r[5], 5'h00};
                day_c    = hour_r[5];
            end else begin
                hour_nxt = {2'b00, hour_r[5], h12_low[4:0]};
            end
        end
        // Weekday and date
        if (day_c) begin
            wday_nxt = (wday_r == WDAY_LAST) ? 3'h0 : wday_r + 3'h1; // RULE_02
            if (date_r == last_day(month_r, leap_r)) begin // RULE_22
                date_nxt = 8'h01;
                mon_c    = 1'b1;
            end else begin
                date_nxt = bcd_inc(date_r); // RULE_03
            end
        end
        // Month and year
        if (mon_c) begin
            if (month_r == MONTH_LAST) begin // RULE_05
                month_nxt = 8'h01;
                year_c    = 1'b1;
            end else begin
                month_nxt = bcd_inc(month_r);
            end
        end
        if (year_c) begin
            year_nxt = (year_r == YEAR_LAST) ? 8'h00 : bcd_inc(year_r); // RULE_08
            leap_nxt = leap_r + 2'h1; // RULE_22
        end
    end

    // Clock page counters; a bus write wins over a tick
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sec_r   <= RST_SEC;
            min_r   <= RST_SEC;
            hour_r  <= RST_HOUR;
            wday_r  <= RST_WDAY[2:0];
            date_r  <= RST_DATE;
            month_r <= RST_MONTH;
            year_r  <= RST_YEAR;
        end else begin
            sec_r   <= wr_at(OFS_SEC) ? (wd & SEC_MASK) : sec_nxt;
            min_r   <= wr_at(OFS_MIN) ? (wd & SEC_MASK) : min_nxt;
            hour_r  <= (wr_at(OFS_HOUR) && !page_r) ? (wd & HOUR_MASK) : hour_nxt; // RULE_01
            wday_r  <= (wr_at(OFS_WDAY) && !page_r) ? wd[2:0] : wday_nxt; // RULE_02
            date_r  <= (wr_at(OFS_DATE) && !page_r) ? (wd & DATE_MASK) : date_nxt; // RULE_03
            month_r <= (wr_at(OFS_MONTH) && !page_r) ? (wd & MONTH_MASK) : month_nxt; // RULE_05
            year_r  <= (wr_at(OFS_YEAR) && !page_r) ? wd : year_nxt; // RULE_08
        end
    end

    // Alarm page fields, format and leap cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            a_hour_r <= RST_HOUR;
            a_wday_r <= RST_WDAY[2:0];
            a_date_r <= RST_DATE;
            fmt_r    <= 1'b0;
            leap_r   <= RST_LEAP;
        end else begin
            if (wr_at(OFS_HOUR) && page_r) begin
                a_hour_r <= wd & HOUR_MASK; // RULE_23
            end
            if (wr_at(OFS_WDAY) && page_r) begin
                a_wday_r <= wd[2:0];
            end
            if (wr_at(OFS_DATE) && page_r) begin
                a_date_r <= wd & DATE_MASK;
            end
            if (wr_at(OFS_MONTH) && page_r) begin
                fmt_r <= wd[FMT_BIT]; // RULE_06
            end
            if (wr_at(OFS_YEAR) && page_r) begin
                leap_r <= wd[1:0]; // RULE_09
            end else begin
                leap_r <= leap_nxt;
            end
        end
    end

    // Control register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            page_r     <= 1'b0; // RULE_19
            irq_en_r   <= 1'b0;
            alarm_en_r <= 1'b0;
            run_en_r   <= 1'b0;
        end else if (wr_at(OFS_CTL)) begin
            page_r     <= wd[CTL_PAGE_BIT]; // RULE_10
            alarm_en_r <= wd[CTL_ALARM_BIT]; // RULE_13
            run_en_r   <= wd[CTL_RUN_BIT]; // RULE_12
            irq_en_r   <= wd[CTL_IRQ_BIT];
        end
    end

    // Rounding request: a new write of 1 wins over service
    always_ff @(posedge core_clk) begin
        if (rst) begin
            round_pend_r <= 1'b0; // RULE_19
        end else if (wr_at(OFS_CTL) && wd[CTL_ROUND_BIT]) begin
            round_pend_r <= 1'b1; // RULE_15
        end else if (sec_tick) begin
            round_pend_r <= 1'b0; // RULE_18
        end
    end

    // Alarm match, checked one cycle after the tick settles
    assign alarm_match = (sec_r == 8'h00) && (min_r == 8'h00) &&
                         (hour_r == a_hour_r) && (wday_r == a_wday_r) &&
                         (date_r == a_date_r);

    always_ff @(posedge core_clk) begin
        if (rst) begin
            clock_interrupt <= 1'b0;
        end else begin
            clock_interrupt <= tick_d_r && alarm_en_r && irq_en_r && alarm_match; // RULE_13
        end
    end

    // Read mux by page
    always_comb begin
        rd_val = 8'h00; // RULE_23
        case (dec[2:0])
            OFS_SEC[4:2]:   rd_val = sec_r;
            OFS_MIN[4:2]:   rd_val = min_r;
            OFS_HOUR[4:2]:  rd_val = page_r ? a_hour_r : hour_r;
            OFS_WDAY[4:2]:  rd_val = {5'h00, page_r ? a_wday_r : wday_r}; // RULE_02
            OFS_DATE[4:2]:  rd_val = page_r ? a_date_r : date_r; // RULE_03
            OFS_MONTH[4:2]: rd_val = page_r ? {7'h00, fmt_r} : month_r; // RULE_06
            OFS_YEAR[4:2]:  rd_val = page_r ? {6'h00, leap_r} : year_r; // RULE_09
            OFS_CTL[4:2]: begin
                rd_val = 8'h00;
                rd_val[CTL_PAGE_BIT]  = page_r;
                rd_val[CTL_ALARM_BIT] = alarm_en_r;
                rd_val[CTL_RUN_BIT]   = run_en_r;
                rd_val[CTL_ROUND_BIT] = round_pend_r; // RULE_18
                rd_val[CTL_IRQ_BIT]   = irq_en_r; // RULE_13
            end
            default: rd_val = 8'h00;
        endcase
        if (!dec[3]) begin
            rd_val = 8'h00;
        end
    end

    // Read data captured at the address phase
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_r <= 32'h0;
        end else if (rd_acc) begin
            rdata_r <= {24'h0, rd_val};
        end
    end

    // Zero-wait, always OKAY
    assign ahb_rsp = '{hreadyout: 1'b1, hresp: 1'b0, hrdata: rdata_r};

endmodule : rtcc_regs

`default_nettype wire

/* File: verif/rtcc_regs_sva.sv */
/*
 * Checker for the calendar page registers: bus answer and interrupt timing.
 * Assumes it is bound to rtcc_regs and sees only that module's ports.
 */
`timescale 1ns/1ps
`default_nettype none

module rtcc_regs_sva #(
    parameter int unsigned LS_EDGES = rtcc_pkg::LS_EDGES_PER_SEC  // Edges per second
) (
    input wire logic                    core_clk,        // Core clock
    input wire logic                    rst,             // Synchronous reset
    input wire rtcc_pkg::rtcc_ahb_req_t ahb_req,         // Bus request
    input wire rtcc_pkg::rtcc_ahb_rsp_t ahb_rsp,         // Bus response
    input wire logic                    ls_clk_in,       // Low-speed clock
    input wire logic                    clock_interrupt  // Interrupt pulse
);
    import rtcc_pkg::*;

    logic        rd_v;   // Read data phase
    logic [4:0]  rd_a;   // Offset of that read
    logic        rd_bad; // Read was unmapped
    logic [2:0]  since;  // Cycles since a low-speed rise
    int unsigned ecnt;   // Rises within the second
    wire take = ahb_req.hsel && ahb_req.hready && ahb_req.htrans == HTRANS_NONSEQ;

    // Track the read whose data phase is current
    always_ff @(posedge core_clk) begin
        rd_v   <= !rst && take && !ahb_req.hwrite;
        rd_a   <= ahb_req.haddr[4:0];
        rd_bad <= ahb_req.haddr[31:5] != 27'h0 || ahb_req.haddr[1:0] != 2'h0;
    end

    // Shadow prescaler, saturating age of last rise
    always_ff @(posedge core_clk) begin
        if (rst) begin
            since <= 3'h7;
            ecnt  <= 0;
        end else if ($rose(ls_clk_in)) begin
            since <= 3'h0;
            ecnt  <= (ecnt == LS_EDGES - 1) ? 0 : ecnt + 1;
        end else if (since != 3'h7) begin
            since <= since + 3'h1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_ready; ahb_rsp.hreadyout && !ahb_rsp.hresp; endproperty
    a_ready: assert property (p_ready) else $error("bus answer not ready or not okay");
    property p_upper; ahb_rsp.hrdata[31:8] == 24'h0; endproperty
    a_upper: assert property (p_upper) else $error("read data upper bits set");
    property p_rst_quiet; $fell(rst) |-> ahb_rsp.hrdata == 32'h0 && !clock_interrupt; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
    property p_hour; rd_v && rd_a == OFS_HOUR |-> ahb_rsp.hrdata[7:6] == 2'h0; endproperty
    a_hour: assert property (p_hour) else $error("hour top bits set");
    property p_wday; rd_v && rd_a == OFS_WDAY |-> ahb_rsp.hrdata[7:3] == 5'h0; endproperty
    a_wday: assert property (p_wday) else $error("weekday top bits set");
    property p_date; rd_v && rd_a == OFS_DATE |-> ahb_rsp.hrdata[7:6] == 2'h0; endproperty
    a_date: assert property (p_date) else $error("date top bits set");
    property p_ctl;
        rd_v && rd_a == OFS_CTL |-> {ahb_rsp.hrdata[6:5], ahb_rsp.hrdata[1]} == 3'h0;
    endproperty
    a_ctl: assert property (p_ctl) else $error("control spare bits set");
    property p_unmap; rd_v && rd_bad |-> ahb_rsp.hrdata == 32'h0; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
    property p_hold; !(take && !ahb_req.hwrite) |=> $stable(ahb_rsp.hrdata); endproperty
    a_hold: assert property (p_hold) else $error("read data moved without a read");
    property p_pulse; clock_interrupt |=> !clock_interrupt; endproperty
    a_pulse: assert property (p_pulse) else $error("interrupt longer than one cycle");
    property p_irq_tick; clock_interrupt |-> ecnt == 0 && since <= 3'h5; endproperty
    a_irq_tick: assert property (p_irq_tick) else $error("interrupt off the second");

    c_irq: cover property (clock_interrupt);
    c_unmap: cover property (rd_v && rd_bad);
    c_round: cover property (rd_v && rd_a == OFS_CTL && ahb_rsp.hrdata[CTL_ROUND_BIT]);

endmodule : rtcc_regs_sva

bind rtcc_regs rtcc_regs_sva #(.LS_EDGES(LS_EDGES)) u_sva (
    .core_clk        (core_clk),
    .rst             (rst),
    .ahb_req         (ahb_req),
    .ahb_rsp         (ahb_rsp),
    .ls_clk_in       (ls_clk_in),
    .clock_interrupt (clock_interrupt)
);

`default_nettype wire

/* File: verif/rtcc_regs_tb.sv */
/*
 * Self-checking bench for the calendar page registers over AHB-Lite.
 * Assumes a shortened second (LS_EDGES 4) and a slow synchronous ls clock.
 */
`timescale 1ns/1ps
`default_nettype none

module rtcc_regs_tb;
    import rtcc_pkg::*;

    localparam int unsigned LSE = 4;  // Edges per simulated second
    localparam logic [4:0] TA [6] = '{OFS_HOUR, OFS_WDAY, OFS_DATE, OFS_MONTH, OFS_YEAR, OFS_CTL};
    localparam logic [7:0] TW [6] = '{8'hc5, 8'hf6, 8'hf1, 8'he8, 8'h99, 8'h62};
    localparam logic [7:0] TE [6] = '{8'h05, 8'h06, 8'h31, 8'h08, 8'h99, 8'h00};
    localparam logic [7:0] TR [5] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h00};
    localparam int         SC [4] = '{29, 30, 0, 59};

    logic          core_clk  = 1'b0;
    logic          rst       = 1'b1;
    logic          ls_clk_in = 1'b0;
    rtcc_ahb_req_t m;          // Master side request
    rtcc_ahb_req_t req;        // Request with bus ready
    rtcc_ahb_rsp_t rsp;
    logic          clock_interrupt;
    logic [31:0]   q;          // Last read data
    int            errors     = 0;
    int            n_compared = 0;
    int            n_irq      = 0;
    integer        seed       = 32'he279;

    always #25 core_clk = ~core_clk;
    assign req = {m[$bits(m)-1:1], rsp.hreadyout};

    rtcc_regs #(.LS_EDGES(LSE)) dut (
        .core_clk        (core_clk),
        .rst             (rst),
        .ahb_req         (req),
        .ahb_rsp         (rsp),
        .ls_clk_in       (ls_clk_in),
        .clock_interrupt (clock_interrupt)
    );

    // Interrupt pulse counter
    always @(posedge core_clk) if (clock_interrupt === 1'b1) n_irq <= n_irq + 1;

    task automatic end_sim;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // One edge, then more until ready, bounded
    task automatic wait_rdy;
        int i;
        @(posedge core_clk);
        for (i = 0; rsp.hreadyout !== 1'b1; i++) begin
            if (i > 40) begin
                errors++;
                end_sim();
            end
            @(posedge core_clk);
        end
    endtask : wait_rdy

    task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d);
        @(posedge core_clk);
        m.hsel   <= 1'b1;
        m.haddr  <= a;
        m.htrans <= HTRANS_NONSEQ;
        m.hwrite <= w;
        m.hsize  <= 3'h2;
        wait_rdy();
        m.htrans <= 2'b00;
        m.hwdata <= {24'h0, d};
        wait_rdy();
        q = rsp.hrdata;
    endtask : bus

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'b1, {27'h0, a}, d);
    endtask : wr

    task automatic rdc(input logic [4:0] a, input logic [7:0] e);
        bus(1'b0, {27'h0, a}, 8'h00);
        chk(q, {24'h0, e});
    endtask : rdc

    // Only valid times are written
    task automatic hms(input logic [7:0] h, input logic [7:0] mi, input logic [7:0] s);
        wr(OFS_HOUR, h);
        wr(OFS_MIN, mi);
        wr(OFS_SEC, s);
    endtask : hms

    // Low-speed clock runs only inside these bursts
    task automatic secs(input int n);
        repeat (n * LSE) begin
            ls_clk_in <= 1'b1;
            repeat (6) @(posedge core_clk);
            ls_clk_in <= 1'b0;
            repeat (6) @(posedge core_clk);
        end
    endtask : secs

    function automatic logic [7:0] bcd(input int n);
        return 8'((n / 10) * 16 + n % 10);
    endfunction : bcd

    initial begin
        int i;
        int s;
        int mn;
        int y;
        int n0;
        m = '0;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        rdc(OFS_CTL, 8'h00);
        $display("reset test done");
        // Spare bits dropped, unmapped reads zero
        for (i = 0; i < 6; i++) begin
            wr(TA[i], TW[i]);
            rdc(TA[i], TE[i]);
        end
        bus(1'b1, 32'h100, 8'h55);
        bus(1'b0, 32'h100, 8'h00);
        chk(q, 32'h0);
        bus(1'b0, 32'h20, 8'h00);
        chk(q, 32'h0);
        $display("spare bit test done");
        // Halted clock keeps its seconds
        wr(OFS_SEC, 8'h10);
        secs(1);
        rdc(OFS_SEC, 8'h10);
        wr(OFS_CTL, 8'h08);
        secs(1);
        rdc(OFS_SEC, 8'h11);
        $display("run test done");
        // Rounding at boundary and random seconds
        for (i = 0; i < 8; i++) begin
            s  = (i < 4) ? SC[i] : ($random(seed) & 32'h7fff) % 60;
            mn = ($random(seed) & 32'h7fff) % 59;
            y  = ($random(seed) & 32'h7fff) % 100;
            wr(OFS_YEAR, bcd(y));
            rdc(OFS_YEAR, bcd(y));
            hms(8'h05, bcd(mn), bcd(s));
            wr(OFS_CTL, 8'h18);
            rdc(OFS_CTL, 8'h18);
            secs(1);
            rdc(OFS_SEC, 8'h00);
            rdc(OFS_MIN, bcd(mn + int'(s >= 30)));
            rdc(OFS_CTL, 8'h08);
        end
        $display("rounding test done");
        // Full rollover onto the reset alarm values
        wr(OFS_CTL, 8'h00);
        hms(8'h31, 8'h59, 8'h59);
        wr(OFS_WDAY, 8'h06);
        wr(OFS_DATE, 8'h31);
        wr(OFS_MONTH, 8'h12);
        wr(OFS_YEAR, 8'h99);
        wr(OFS_CTL, 8'h01);
        wr(OFS_YEAR, 8'h03);
        rdc(OFS_HOUR, 8'h00);
        wr(OFS_CTL, 8'h0c);
        wr(OFS_CTL, 8'h8c);
        n0 = n_irq;
        secs(1);
        chk(32'(n_irq - n0), 32'h1);
        rdc(OFS_SEC, 8'h00);
        for (i = 0; i < 5; i++) rdc(TA[i], TR[i]);
        wr(OFS_CTL, 8'h8d);
        rdc(OFS_YEAR, 8'h00);
        $display("rollover test done");
        // End of February, leap and plain year
        for (i = 0; i < 2; i++) begin
            wr(OFS_CTL, 8'h00);
            wr(OFS_DATE, 8'h28);
            wr(OFS_MONTH, FEB);
            wr(OFS_CTL, 8'h01);
            wr(OFS_YEAR, 8'(i));
            wr(OFS_CTL, 8'h00);
            hms(8'h31, 8'h59, 8'h59);
            wr(OFS_CTL, 8'h08);
            secs(1);
            rdc(OFS_DATE, (i != 0) ? 8'h01 : 8'h29);
            rdc(OFS_MONTH, (i != 0) ? 8'h03 : FEB);
        end
        $display("february test done");
        // 24-hour view, format changed with the clock halted
        wr(OFS_CTL, 8'h01);
        wr(OFS_MONTH, 8'hff);
        rdc(OFS_MONTH, 8'h01);
        wr(OFS_CTL, 8'h00);
        hms(8'h23, 8'h59, 8'h59);
        wr(OFS_CTL, 8'h08);
        secs(1);
        rdc(OFS_HOUR, 8'h00);
        $display("24 hour test done");
        end_sim();
    end

endmodule : rtcc_regs_tb

`default_nettype wire
